// ===== core/i2c_stop_master.sv
// Purpose: Stop-phase sequencer of a two-wire master with collision check
// Assumes: Open-drain lines sampled by the 100 MHz device clock
// Notes:   Start, restart and data phases live elsewhere
`timescale 1ns/1ps

// Behaviour
// - Stop starts data low, clock held low
// - Data seen low, release the clock
// - Clock high, load timer, count down
// - Data low at timer expiry is collision
// - Clock low before data high is collision
// - Bus control register bit layout
// - Collision aborts, releases, clears, flags
// - Data high at timer expiry, a period later done flag
module i2c_stop_master
  import i2c_stop_pkg::*;
(
  input  wire logic              mclk_in,      // Device clock
  input  wire logic              rst_n_in,     // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr_in,      // Register address
  input  wire logic [DATA_W-1:0] wdata_in,     // Write data
  input  wire logic              wr_in,        // Write strobe
  input  wire logic              rd_in,        // Read strobe
  output logic      [DATA_W-1:0] rdata_out,    // Read data, next cycle
  input  wire logic              data_line_pin_in,  // Data line level
  output logic                   data_line_pin_out, // Data drive value
  output logic                   data_line_oe_n_out, // Low while driving
  input  wire logic              clock_line_pin_in,  // Clock line level
  output logic                   clock_line_pin_out, // Clock drive value
  output logic                   clock_line_oe_n_out, // Low while driving
  output logic                   irq_out       // Level interrupt
);
  // Pin synchronisers
  logic           sda_meta;   // First stage, data
  logic           sda_s;      // Synchronised data
  logic           scl_meta;   // First stage, clock
  logic           scl_s;      // Synchronised clock
  logic           sda_prev;   // Previous data sample
  // Registers
  logic [7:0]     control;    // Bus control register
  logic [7:0]     status;     // Bus status register
  logic [6:0]     reload;     // Reload value register
  logic [1:0]     irq_stat;   // Sticky events
  logic [1:0]     irq_mask;   // Event enables
  // Sequencer
  stop_state_type state;      // Stop-phase state
  stop_state_type next_state; // Next state
  logic           drive_sda;  // Pull data line low
  logic           drive_scl;  // Pull clock line low
  logic           collide;    // Collision this cycle
  logic           finish;     // Stop completed this cycle
  logic           lost;       // Bus lost, awaiting free bus
  logic           stop_edge;  // Stop condition on the bus
  logic           start_edge; // Start condition on the bus
  logic           ctl_wr;     // Control register write
  logic           irq_rd;     // Interrupt status read
  logic [1:0]     irq_set;    // Events this cycle
  bit_timer_if    tmr ();     // Timer wires

  // Timer instance
  bit_timer u_timer (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .tmr      (tmr.timer)
  );

  // Two-stage sampling of both bus lines
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      sda_meta <= data_line_pin_in;
      sda_s    <= sda_meta;
      scl_meta <= clock_line_pin_in;
      scl_s    <= scl_meta;
      sda_prev <= sda_s;
    end
  end

  // Bus condition detectors on synchronised levels
  assign stop_edge  = scl_s && sda_s && !sda_prev;
  assign start_edge = scl_s && !sda_s && sda_prev;

  // Bus access decode
  assign ctl_wr = wr_in && (addr_in == OFS_CONTROL);
  assign irq_rd = rd_in && (addr_in == OFS_IRQ_STAT);

  // Next-state logic of the stop sequencer
  always_comb
  begin
    next_state = state;
    collide    = 1'b0;
    finish     = 1'b0;
    tmr.load   = 1'b0;
    case (state)
      ST_IDLE:
        // A set stop request launches the sequence
        if (control[CTL_STOP])
          next_state = ST_DRIVE_DATA;
      ST_DRIVE_DATA:
        // Clock held until data and own clock read low
        if (!sda_s && !scl_s)
          next_state = ST_WAIT_CLOCK;
      ST_WAIT_CLOCK:
        // Clock arbitration: wait for a real high
        if (scl_s)
        begin
          tmr.load   = 1'b1;
          next_state = ST_CLOCK_HIGH;
        end
      ST_CLOCK_HIGH:
        // Someone pulled the clock while data still low
        if (!scl_s)
        begin
          collide    = 1'b1;
          next_state = ST_IDLE;
        end
        else if (tmr.expired)
        begin
          tmr.load   = 1'b1;
          next_state = ST_DATA_RELEASED;
        end
      ST_DATA_RELEASED:
        // Clock low before data rose is a collision
        if (!scl_s && !sda_s)
        begin
          collide    = 1'b1;
          next_state = ST_IDLE;
        end
        else if (tmr.expired)
        begin
          if (!sda_s)
          begin
            collide    = 1'b1;
            next_state = ST_IDLE;
          end
          else
          begin
            tmr.load   = 1'b1;
            next_state = ST_TAIL;
          end
        end
      ST_TAIL:
        // One more bit period, then done
        if (tmr.expired)
        begin
          finish     = 1'b1;
          next_state = ST_IDLE;
        end
      default:
        next_state = ST_IDLE;
    endcase
  end
  assign tmr.reload = reload;

  // State register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Line drive: data low until released, clock low until data seen low
  assign drive_sda = (state == ST_DRIVE_DATA) || (state == ST_WAIT_CLOCK)
                   || (state == ST_CLOCK_HIGH);
  assign drive_scl = (state == ST_DRIVE_DATA);
  assign data_line_pin_out   = 1'b0;
  assign clock_line_pin_out  = 1'b0;
  assign data_line_oe_n_out  = !drive_sda;
  assign clock_line_oe_n_out = !drive_scl;

  // Bus control register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      control <= RST_CONTROL;
    else
    begin
      if (ctl_wr)
      begin
        // Acknowledge status is read-only
        control[CTL_GENERAL_CALL] <= wdata_in[CTL_GENERAL_CALL];
        control[CTL_ACK_VALUE]    <= wdata_in[CTL_ACK_VALUE];
        control[CTL_ACK_SEQ]      <= wdata_in[CTL_ACK_SEQ];
        control[CTL_RECEIVE]      <= wdata_in[CTL_RECEIVE];
        control[CTL_RESTART]      <= wdata_in[CTL_RESTART];
        // Start is refused while the bus is lost
        if (!lost)
          control[CTL_START] <= wdata_in[CTL_START];
        // Stop requests only set; hardware clears
        if (wdata_in[CTL_STOP])
          control[CTL_STOP] <= 1'b1;
      end
      // Sequence end or abort clears the request
      if (collide || finish)
        control[CTL_STOP] <= 1'b0;
    end
  end

  // Bus status register: stop and start seen
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      status <= RST_STATUS;
    else
    begin
      if (wr_in && (addr_in == OFS_STATUS))
      begin
        // Only phase and edge select are writable
        status[STA_SAMPLE_PHASE] <= wdata_in[STA_SAMPLE_PHASE];
        status[STA_EDGE_SELECT]  <= wdata_in[STA_EDGE_SELECT];
      end
      if (stop_edge)
      begin
        status[STA_STOP_SEEN]  <= 1'b1;
        status[STA_START_SEEN] <= 1'b0;
      end
      else if (start_edge)
      begin
        status[STA_START_SEEN] <= 1'b1;
        status[STA_STOP_SEEN]  <= 1'b0;
      end
    end
  end

  // Reload register, low seven bits
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reload <= RST_RELOAD;
    else if (wr_in && (addr_in == OFS_RELOAD))
      reload <= wdata_in[6:0];
  end

  // Lost-bus tracking: freed by a stop or an idle bus
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      lost <= 1'b0;
    else if (collide)
      lost <= 1'b1;
    else if (stop_edge || (scl_s && sda_s && state == ST_IDLE))
      lost <= 1'b0;
  end

  // Sticky interrupt status: read clears, set wins
  assign irq_set[IRQ_COLLISION] = collide;
  assign irq_set[IRQ_DONE]      = finish;
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_stat <= RST_IRQ;
    else if (irq_rd)
      irq_stat <= irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  // Interrupt mask register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_mask <= RST_IRQ;
    else if (wr_in && (addr_in == OFS_IRQ_MASK))
      irq_mask <= wdata_in[IRQ_BITS-1:0];
  end
  assign irq_out = |(irq_stat & irq_mask);

  // Read data, one cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rdata_out <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        OFS_CONTROL:  rdata_out <= control;
        OFS_STATUS:   rdata_out <= status;
        OFS_RELOAD:   rdata_out <= {1'b0, reload};
        OFS_IRQ_STAT: rdata_out <= {6'h00, irq_stat};
        OFS_IRQ_MASK: rdata_out <= {6'h00, irq_mask};
        default:      rdata_out <= 8'h00;
      endcase
    end
  end

  // Clock held low while data not yet seen low
  chk_clock_hold_low: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_DRIVE_DATA) |-> (!clock_line_oe_n_out && !data_line_oe_n_out))
    else $error("clock not held low during stop start");

  // Data seen low releases the clock next cycle
  chk_clock_release: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_DRIVE_DATA && !sda_s && !scl_s) |=> clock_line_oe_n_out)
    else $error("clock not released after data low");

  // Timer loaded in clock wait only when clock high
  chk_timer_load: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_WAIT_CLOCK && tmr.load) |-> scl_s ##1 tmr.running)
    else $error("timer load without clock high");

  // Data low at expiry yields collision flag
  chk_expiry_collide: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_DATA_RELEASED && tmr.expired && scl_s && !sda_s)
    |=> (irq_stat[IRQ_COLLISION] && state == ST_IDLE))
    else $error("missed collision at timer expiry");

  // Clock dropping while data held low is a collision
  chk_clock_collide: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (state == ST_CLOCK_HIGH && !scl_s) |=> (state == ST_IDLE && lost))
    else $error("missed clock-low collision");

  // Abort releases lines and clears stop request
  chk_abort_release: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    collide |=> (data_line_oe_n_out && clock_line_oe_n_out
                 && !control[CTL_STOP]))
    else $error("abort left line driven or request set");

  // Stop edge on bus sets stop-seen
  chk_stop_seen: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    stop_edge |=> status[STA_STOP_SEEN])
    else $error("stop seen bit not set");

  // Successful end clears request and flags done
  chk_done_flag: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    finish |=> (!control[CTL_STOP] && irq_stat[IRQ_DONE]))
    else $error("stop completion not reported");

  // Start write ignored while bus lost
  chk_start_refused: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (lost && !control[CTL_START]) |=> !control[CTL_START])
    else $error("start accepted on lost bus");

  // Interrupt level rises with a masked done status bit
  chk_irq_level: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    $rose(irq_stat[IRQ_DONE]) && irq_mask[IRQ_DONE] |-> irq_out)
    else $error("interrupt output not raised");
endmodule : i2c_stop_master

// ===== core/i2c_stop_pkg.sv
// Purpose: Shared constants for the stop-phase bus master
// Assumes: 8-bit register port, 100 MHz device clock
// Notes:   Offsets of the register port are local choices
package i2c_stop_pkg;
  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int TMR_W  = 7;
  // Register offsets
  localparam logic [2:0] OFS_CONTROL  = 3'h0;
  localparam logic [2:0] OFS_STATUS   = 3'h1;
  localparam logic [2:0] OFS_RELOAD   = 3'h2;
  localparam logic [2:0] OFS_IRQ_STAT = 3'h3;
  localparam logic [2:0] OFS_IRQ_MASK = 3'h4;
  // Bus control fields
  localparam int CTL_GENERAL_CALL = 7;
  localparam int CTL_ACK_RECEIVED = 6;
  localparam int CTL_ACK_VALUE    = 5;
  localparam int CTL_ACK_SEQ      = 4;
  localparam int CTL_RECEIVE      = 3;
  localparam int CTL_STOP         = 2;
  localparam int CTL_RESTART      = 1;
  localparam int CTL_START        = 0;
  // Bus status fields
  localparam int STA_SAMPLE_PHASE = 7;
  localparam int STA_EDGE_SELECT  = 6;
  localparam int STA_DATA_ADDR    = 5;
  localparam int STA_STOP_SEEN    = 4;
  localparam int STA_START_SEEN   = 3;
  localparam int STA_READ_WRITE   = 2;
  localparam int STA_UPDATE_ADDR  = 1;
  localparam int STA_BUFFER_FULL  = 0;
  // Interrupt status fields
  localparam int IRQ_COLLISION = 0;
  localparam int IRQ_DONE      = 1;
  localparam int IRQ_BITS      = 2;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS  = 8'h00;
  localparam logic [6:0] RST_RELOAD  = 7'h04;
  localparam logic [1:0] RST_IRQ     = 2'h0;
  // Stop-phase sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DRIVE_DATA, ST_WAIT_CLOCK, ST_CLOCK_HIGH,
    ST_DATA_RELEASED, ST_TAIL
  } stop_state_type;
endpackage : i2c_stop_pkg

// ===== core/bit_timer_if.sv
// Purpose: Load and expiry wires between sequencer and bit timer
// Assumes: Single device clock
// Notes:   Expired is a one-cycle pulse
`timescale 1ns/1ps
interface bit_timer_if;
  logic       load;    // Reload request pulse
  logic [6:0] reload;  // Reload count
  logic       expired; // Countdown reached zero
  logic       running; // Countdown in progress
  modport ctrl  (output load, output reload, input expired, input running);
  modport timer (input load, input reload, output expired, output running);
endinterface : bit_timer_if

// ===== core/bit_timer.sv
// Purpose: Reloadable down-counter giving one bit period
// Assumes: Ticks once per device clock
// Notes:   Expires reload+1 cycles after a load
`timescale 1ns/1ps
module bit_timer
  import i2c_stop_pkg::*;
(
  input  wire logic  mclk_in,  // Device clock
  input  wire logic  rst_n_in, // Async reset, active low
  bit_timer_if.timer tmr       // Timer port
);
  logic [TMR_W-1:0] count;  // Remaining ticks
  logic             active; // Counting

  // Countdown; a load restarts it at once
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count  <= '0;
      active <= 1'b0;
    end
    else if (tmr.load)
    begin
      count  <= tmr.reload;
      active <= 1'b1;
    end
    else if (active)
    begin
      if (count == '0)
        active <= 1'b0;
      else
        count <= count - 1'b1;
    end
  end

  // Expiry pulse in the last counting cycle; not gated by load, the
  // sequencer reloads on expiry and gating would close a loop
  assign tmr.expired = active && (count == '0);
  assign tmr.running = active;
endmodule : bit_timer

// ===== dv/bus_peer_model.sv
// Purpose: Other masters and targets on the shared two-wire bus
// Assumes: Both lines have pull-ups; any party may pull them low
// Notes:   Stretch holds the clock low after each device release
`timescale 1ns/1ps
module bus_peer_model
(
  input  wire logic       mclk_in,        // Device clock
  input  wire logic       rst_n_in,       // Reset, active low
  input  wire logic       data_oe_n_in,   // Device pulls data when low
  input  wire logic       clock_oe_n_in,  // Device pulls clock when low
  input  wire logic       hold_data_in,   // Peer pulls data low
  input  wire logic       hold_clock_in,  // Peer pulls clock low
  input  wire logic [3:0] stretch_in,     // Clock stretch length
  output logic            data_wire_out,  // Resolved data line
  output logic            clock_wire_out  // Resolved clock line
);
  logic [3:0] stretch_cnt;  // Remaining stretch cycles

  // Slow target holds the clock after the device lets it go
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stretch_cnt <= 4'h0;
    end
    else
    begin
      // Armed while the device pulls, so no high glitch at release
      if (!clock_oe_n_in)
        stretch_cnt <= stretch_in;
      else if (stretch_cnt != 4'h0)
        stretch_cnt <= stretch_cnt - 4'h1;
    end
  end

  // Wired-and of all parties, pull-up when released
  assign clock_wire_out = clock_oe_n_in & ~hold_clock_in
                          & (stretch_cnt == 4'h0);
  assign data_wire_out  = data_oe_n_in & ~hold_data_in;
endmodule : bus_peer_model

// ===== dv/i2c_stop_master_bench.sv
// Purpose: Self-checking bench of the stop-phase bus master
// Assumes: Peer model resolves both open-drain lines
// Notes:   Reload raised to 6 from its reset value of 4
`timescale 1ns/1ps
module i2c_stop_master_bench;
  import i2c_stop_pkg::*;
  localparam logic [7:0] RELOAD = 8'h06;  // Bit timer reload used
  logic              mclk_in;     // Device clock
  logic              rst_n_in;    // Reset, active low
  logic [ADDR_W-1:0] addr_in;     // Register address
  logic [DATA_W-1:0] wdata_in;    // Write data
  logic              wr_in;       // Write strobe
  logic              rd_in;       // Read strobe
  logic [DATA_W-1:0] rdata_out;   // Read data
  logic              data_wire;   // Resolved data line
  logic              clock_wire;  // Resolved clock line
  logic              data_oe_n;   // Device pulls data when low
  logic              clock_oe_n;  // Device pulls clock when low
  logic              irq_out;     // Interrupt level
  logic              data_drv;    // Data drive value
  logic              clock_drv;   // Clock drive value
  logic              hold_data;   // Peer pulls data low
  logic              hold_clock;  // Peer pulls clock low
  logic [3:0]        stretch;     // Peer stretch length
  logic [7:0]        v;           // Read result
  logic [7:0]        rst_tab [6]; // Reset values by offset
  int                error_cnt;
  int                comparisons;
  int                cycle_cnt;
  int                n;

  i2c_stop_master dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .data_line_pin_in(data_wire),
    .data_line_pin_out(data_drv), .data_line_oe_n_out(data_oe_n),
    .clock_line_pin_in(clock_wire), .clock_line_pin_out(clock_drv),
    .clock_line_oe_n_out(clock_oe_n), .irq_out(irq_out));

  bus_peer_model peer_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .data_oe_n_in(data_oe_n), .clock_oe_n_in(clock_oe_n),
    .hold_data_in(hold_data), .hold_clock_in(hold_clock),
    .stretch_in(stretch), .data_wire_out(data_wire),
    .clock_wire_out(clock_wire));

  // Free-running device clock
  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  // Hang guard
  always @(posedge mclk_in)
  begin
    cycle_cnt++;
    if (cycle_cnt == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_reg

  task automatic check_bit(input logic got, input logic exp);
    check_reg({7'h00, got}, {7'h00, exp});
  endtask : check_bit

  // One write, then an idle cycle
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask : reg_write

  // Read data stand from the cycle after the strobe until the next read
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    @(posedge mclk_in);
  endtask : reg_read

  task automatic read_check(input logic [2:0] a, input logic [7:0] exp);
    reg_read(a, v);
    check_reg(v, exp);
  endtask : read_check

  // Wait for clock oe (0), data oe (1) or irq (2) to reach a level
  task automatic wait_sig(input int sel, input logic val, input int lim,
                          output int cnt);
    logic s;
    cnt = 0;
    forever
    begin
      #1 s = (sel == 0) ? clock_oe_n : (sel == 1) ? data_oe_n : irq_out;
      if (s === val || cnt >= lim)
        break;
      @(posedge mclk_in);
      cnt++;
    end
    check_bit(s, val);
    @(posedge mclk_in);
  endtask : wait_sig

  // Main sequence
  initial
  begin
    rst_tab = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};
    {rst_n_in, wr_in, rd_in, hold_data, hold_clock} = 5'h00;
    addr_in = '0;
    wdata_in = '0;
    stretch = 4'h0;
    error_cnt = 0;
    comparisons = 0;
    cycle_cnt = 0;
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    // Reset values, unmapped offset reads zero
    for (int i = 0; i < 6; i++)
      read_check(3'(i), rst_tab[i]);
    // Field layouts and read-only bits
    reg_write(OFS_CONTROL, 8'hE8);
    read_check(OFS_CONTROL, 8'hA8);
    reg_write(OFS_CONTROL, 8'h00);
    reg_write(OFS_STATUS, 8'hFF);
    read_check(OFS_STATUS, 8'hC0);
    reg_write(OFS_STATUS, 8'h00);
    reg_write(3'h5, 8'hFF);
    read_check(3'h5, 8'h00);
    reg_write(OFS_RELOAD, RELOAD);
    read_check(OFS_RELOAD, RELOAD);
    // Clean stop with a stretching target
    reg_write(OFS_IRQ_MASK, 8'h03);
    stretch <= 4'h5;
    reg_write(OFS_CONTROL, 8'h04);
    #1 check_bit(data_oe_n, 1'b0);
    check_bit(clock_oe_n, 1'b0);
    check_bit(data_drv | clock_drv, 1'b0);
    @(posedge mclk_in);
    wait_sig(0, 1'b1, 10, n);
    wait_sig(1, 1'b1, 60, n);
    check_bit(n >= RELOAD + 5 && n <= RELOAD + 14, 1'b1);
    wait_sig(2, 1'b1, 60, n);
    check_bit(n >= RELOAD, 1'b1);
    read_check(OFS_STATUS, 8'h10);
    read_check(OFS_CONTROL, 8'h00);
    read_check(OFS_IRQ_STAT, 8'h02);
    #1 check_bit(irq_out, 1'b0);
    @(posedge mclk_in);
    // Data held low by another master past the timer
    stretch <= 4'h0;
    hold_data <= 1'b1;
    reg_write(OFS_CONTROL, 8'h04);
    wait_sig(2, 1'b1, 80, n);
    read_check(OFS_IRQ_STAT, 8'h01);
    read_check(OFS_CONTROL, 8'h00);
    read_check(OFS_STATUS, 8'h08);
    #1 check_bit(data_oe_n & clock_oe_n, 1'b1);
    @(posedge mclk_in);
    reg_write(OFS_CONTROL, 8'h01);
    read_check(OFS_CONTROL, 8'h00);
    hold_data <= 1'b0;
    repeat (8) @(posedge mclk_in);
    read_check(OFS_STATUS, 8'h10);
    reg_write(OFS_CONTROL, 8'h01);
    read_check(OFS_CONTROL, 8'h01);
    reg_write(OFS_CONTROL, 8'h00);
    // Clock pulled low before data rises, interrupt masked
    reg_write(OFS_IRQ_MASK, 8'h00);
    reg_write(OFS_CONTROL, 8'h04);
    wait_sig(0, 1'b1, 10, n);
    repeat (4) @(posedge mclk_in);
    hold_clock <= 1'b1;
    wait_sig(1, 1'b1, 8, n);
    check_bit(clock_oe_n, 1'b1);
    check_bit(irq_out, 1'b0);
    reg_write(OFS_IRQ_MASK, 8'h01);
    #1 check_bit(irq_out, 1'b1);
    @(posedge mclk_in);
    read_check(OFS_IRQ_STAT, 8'h01);
    read_check(OFS_CONTROL, 8'h00);
    #1 check_bit(irq_out, 1'b0);
    hold_clock <= 1'b0;
    @(posedge mclk_in);
    finish_test();
  end
endmodule : i2c_stop_master_bench
